// ===== pkg/stx_defs.vh
`ifndef STX_DEFS_VH
`define STX_DEFS_VH
// Register byte offsets
`define STX_CTRL_OFS 8'h00
`define STX_SYNC1_OFS 8'h04
`define STX_SYNC2_OFS 8'h08
`define STX_DATA_OFS 8'h0C
`define STX_CMD_OFS 8'h10
`define STX_STAT_OFS 8'h14
// Control fields
`define STX_CTRL_EN 0
`define STX_CTRL_CRCEN 1
`define STX_CTRL_BISYNC 2
`define STX_CTRL_POLY 3
`define STX_CTRL_AUTO 4
`define STX_CTRL_W 5
// Command fields
`define STX_CMD_RST_CRC 0
`define STX_CMD_RST_EOM 1
`define STX_CMD_RST_TXINT 2
`define STX_CMD_RST_EXT 3
// Status fields
`define STX_ST_BUFEMPTY 0
`define STX_ST_EOM 1
`define STX_ST_TXINT 2
`define STX_ST_EXTINT 3
`define STX_ST_BUFFULL 4
`define STX_ST_TXON 5
`define STX_ST_CRC 6
// Reset values
`define STX_CTRL_RST 5'h00
`define STX_SYNC_RST 8'h00
`define STX_CRC_RST 16'h0000
// Polynomials, shifted msb first
`define STX_POLY_CRC16 16'h8005
`define STX_POLY_SDLC 16'h1021
// Character kinds in the shift register
`define STX_K_IDLE 2'd0
`define STX_K_DATA 2'd1
`define STX_K_SYNC 2'd2
`define STX_K_CRC 2'd3
// Bits per character
`define STX_CHAR_BITS 4'd8
`endif

// ===== verilog/stx_sync_tx.v
// Function
// - Buffer-empty sets on move to shifter, clears on host buffer write.
// - Service request output tells DMA the buffer wants a character.
// - Shifter empty with no buffered character means transmit underrun.
// - Underrun sends syncs if latch set or last character not data, else CRC then syncs.
// - Reset sets the underrun/end-of-message latch, so idle syncs are default.
// - Automatically inserted syncs never enter the CRC.
// - Host may clear latch anytime; next underrun after a data character sends 16-bit CRC, syncs.
// - Underrun raises external/status interrupt whenever latch becomes set.
// - Sync-only end: transmit interrupt on first sync load, both bits set.
// - CRC end: latch set, empty clear during CRC, then set on sync.
// - CRC accumulates from first data character; host resets it first.
// - CRC inclusion sampled from enable when character enters shifter.
// - Disable finishes current data or sync character, then line marks.
// - Disable leaves a buffered character in place.
// - Disable during CRC completes 16 bits, syncs replacing remaining bits.
// - Bisync filler is always first sync word then second.
// - Reset-transmit-interrupt command clears it and stops requests till data.
// - Data loaded during CRC follows the CRC, with transmit interrupt.
// - Reset-external-status command drops the external/status interrupt.
// - Buffered characters are data even if they match sync patterns.
// - Transmit interrupt each time the buffer becomes empty.
// - Line held marking after reset or while transmitter is off.
// - CRC polynomial selectable, CRC-16 or SDLC, resets to zeros.
`timescale 1ns/1ps
`include "stx_defs.vh"

module stx_sync_tx (
  input wire pclk, // Bus and logic clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready, no wait
  output wire pslverr, // APB error, unmapped
  input wire serial_tx_clock, // Transmit clock pin
  input wire tx_auto_enable, // Auto enable pin, high allows
  output wire serial_tx_data, // Serial data out
  output wire tx_service_request, // DMA request, high
  output wire tx_int_req, // Transmit interrupt pending
  output wire ext_int_req // External/status pending
);

  // Pin synchronisers and edge history
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg aen_s1_q;
  reg aen_s2_q;

  // Software state
  reg [`STX_CTRL_W-1:0] ctrl_q;
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  reg [7:0] buf_q;
  reg buf_full_q;
  reg buf_empty_q;
  reg eom_q;
  reg txint_q;
  reg extint_q;
  reg arm_q;

  // Shifter state
  reg [15:0] crc_q;
  reg [7:0] sr_q;
  reg [3:0] cnt_q;
  reg [1:0] kind_q;
  reg incl_q;
  reg crc2_pend_q;
  reg sync2_pend_q;
  reg crc_abort_q;
  reg txd_q;

  // Bus decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire mapped = (paddr == `STX_CTRL_OFS) | (paddr == `STX_SYNC1_OFS) |
    (paddr == `STX_SYNC2_OFS) | (paddr == `STX_DATA_OFS) |
    (paddr == `STX_CMD_OFS) | (paddr == `STX_STAT_OFS);
  wire wr_ctrl = wr & (paddr == `STX_CTRL_OFS);
  wire wr_sync1 = wr & (paddr == `STX_SYNC1_OFS);
  wire wr_sync2 = wr & (paddr == `STX_SYNC2_OFS);
  wire wr_data = wr & (paddr == `STX_DATA_OFS);
  wire wr_cmd = wr & (paddr == `STX_CMD_OFS);
  wire cmd_rst_crc = wr_cmd & pwdata[`STX_CMD_RST_CRC];
  wire cmd_rst_eom = wr_cmd & pwdata[`STX_CMD_RST_EOM];
  wire cmd_rst_txint = wr_cmd & pwdata[`STX_CMD_RST_TXINT];
  wire cmd_rst_ext = wr_cmd & pwdata[`STX_CMD_RST_EXT];

  // Zero wait states keep the master simple
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Transmitter on: enable bit and, in auto mode, the pin
  wire bisync = ctrl_q[`STX_CTRL_BISYNC];
  wire tx_on = ctrl_q[`STX_CTRL_EN] &
    (~ctrl_q[`STX_CTRL_AUTO] | aen_s2_q);
  wire fall = sck_s3_q & ~sck_s2_q;
  wire [15:0] poly = ctrl_q[`STX_CTRL_POLY] ? `STX_POLY_SDLC :
    `STX_POLY_CRC16;

  wire [7:0] status = {1'b0, (kind_q == `STX_K_CRC), tx_on, buf_full_q,
    extint_q, txint_q, eom_q, buf_empty_q};

  // One serial CRC step, data bit in at the top
  function [15:0] crc_step;
    input [15:0] c;
    input b;
    input [15:0] p;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? p : 16'h0000);
    end
  endfunction

  // Choice of the next character at a boundary
  reg [1:0] ld_kind;
  reg [7:0] ld_char;
  reg ld_incl;
  always @* begin
    ld_kind = `STX_K_IDLE;
    ld_char = 8'hFF;
    ld_incl = 1'b0;
    if (crc2_pend_q) begin
      // Second CRC byte slot always goes, even when disabled; sync bits after an abort
      ld_kind = `STX_K_CRC;
      ld_char = crc_abort_q ? (bisync ? sync2_q : sync1_q) : crc_q[15:8];
    end else if (!tx_on) begin
      ld_kind = `STX_K_IDLE;
    end else if (sync2_pend_q) begin
      ld_kind = `STX_K_SYNC;
      ld_char = sync2_q;
    end else if (buf_full_q) begin
      // Buffered bytes are data whatever their value
      ld_kind = `STX_K_DATA;
      ld_char = buf_q;
      ld_incl = ctrl_q[`STX_CTRL_CRCEN];
    end else if (!eom_q && kind_q == `STX_K_DATA) begin
      ld_kind = `STX_K_CRC;
      ld_char = crc_q[7:0];
    end else begin
      ld_kind = `STX_K_SYNC;
      ld_char = sync1_q;
    end
  end

  // Disable during a CRC byte swaps its unsent bits for sync bits
  wire abort_now = (kind_q == `STX_K_CRC) & ~tx_on & ~crc_abort_q &
    (cnt_q != 4'd0);
  wire [7:0] sync_pick = crc2_pend_q ? sync1_q : (bisync ? sync2_q : sync1_q);
  wire [3:0] done_bits = `STX_CHAR_BITS - cnt_q;
  wire [7:0] sr_eff = abort_now ? (sync_pick >> done_bits) : sr_q;

  // Pin synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      aen_s1_q <= 1'b0;
      aen_s2_q <= 1'b0;
    end else begin
      sck_s1_q <= serial_tx_clock;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      aen_s1_q <= tx_auto_enable;
      aen_s2_q <= aen_s1_q;
    end
  end

  // Read data captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `STX_CTRL_OFS: prdata <= {27'h000_0000, ctrl_q};
        `STX_SYNC1_OFS: prdata <= {24'h00_0000, sync1_q};
        `STX_SYNC2_OFS: prdata <= {24'h00_0000, sync2_q};
        `STX_STAT_OFS: prdata <= {24'h00_0000, status};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Plain configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `STX_CTRL_RST;
      sync1_q <= `STX_SYNC_RST;
      sync2_q <= `STX_SYNC_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[`STX_CTRL_W-1:0];
      end
      if (wr_sync1) begin
        sync1_q <= pwdata[7:0];
      end
      if (wr_sync2) begin
        sync2_q <= pwdata[7:0];
      end
    end
  end

  // Character boundary on a transmit clock fall
  wire load = fall & (cnt_q == 4'd0);
  wire ld_data = load & (ld_kind == `STX_K_DATA);
  wire ld_crc1 = load & (ld_kind == `STX_K_CRC) & ~crc2_pend_q;
  wire ld_sync = load & (ld_kind == `STX_K_SYNC);
  wire first_sync = ld_sync & (kind_q == `STX_K_DATA || kind_q == `STX_K_CRC);

  // Buffer and status flags; hardware sets win over command clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= 8'h00;
      buf_full_q <= 1'b0;
      buf_empty_q <= 1'b1;
      eom_q <= 1'b1;
      txint_q <= 1'b0;
      extint_q <= 1'b0;
      arm_q <= 1'b1;
    end else begin
      // A write in the load cycle refills the buffer, nothing lost
      if (wr_data) begin
        buf_q <= pwdata[7:0];
        buf_full_q <= 1'b1;
      end else if (ld_data) begin
        buf_full_q <= 1'b0;
      end
      // Empty status
      if (wr_data) begin
        buf_empty_q <= 1'b0;
      end else if (ld_data || first_sync) begin
        buf_empty_q <= 1'b1;
      end else if (ld_crc1) begin
        buf_empty_q <= 1'b0;
      end
      // Latch clears on command, sets when CRC starts
      if (ld_crc1) begin
        eom_q <= 1'b1;
      end else if (cmd_rst_eom) begin
        eom_q <= 1'b0;
      end
      // Transmit interrupt
      if (ld_data || first_sync) begin
        txint_q <= 1'b1;
      end else if (cmd_rst_txint) begin
        txint_q <= 1'b0;
      end
      // External/status interrupt on underrun with latch set
      if (ld_crc1 || (first_sync && kind_q == `STX_K_DATA)) begin
        extint_q <= 1'b1;
      end else if (cmd_rst_ext) begin
        extint_q <= 1'b0;
      end
      // Request arming
      if (wr_data) begin
        arm_q <= 1'b1;
      end else if (cmd_rst_txint) begin
        arm_q <= 1'b0;
      end
    end
  end

  // DMA asks only while enabled, empty and armed
  assign tx_service_request = tx_on & buf_empty_q & arm_q;
  assign tx_int_req = txint_q;
  assign ext_int_req = extint_q;
  assign serial_tx_data = txd_q;

  // Shifter, CRC accumulator and sequence flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= `STX_CRC_RST;
      sr_q <= 8'hFF;
      cnt_q <= 4'd0;
      kind_q <= `STX_K_IDLE;
      incl_q <= 1'b0;
      crc2_pend_q <= 1'b0;
      sync2_pend_q <= 1'b0;
      crc_abort_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      if (load) begin
        kind_q <= ld_kind;
        incl_q <= ld_incl;
        if (ld_kind == `STX_K_IDLE) begin
          txd_q <= 1'b1;
          sync2_pend_q <= 1'b0;
          crc_abort_q <= 1'b0;
        end else begin
          // First bit leaves at once, lsb first
          txd_q <= ld_char[0];
          sr_q <= {1'b1, ld_char[7:1]};
          cnt_q <= `STX_CHAR_BITS - 4'd1;
        end
        if (cmd_rst_crc) begin
          crc_q <= `STX_CRC_RST;
        end else if (ld_incl) begin
          crc_q <= crc_step(crc_q, ld_char[0], poly);
        end
        // Two-byte CRC sequencing
        if (ld_kind == `STX_K_CRC) begin
          crc2_pend_q <= ~crc2_pend_q;
        end else begin
          crc_abort_q <= 1'b0;
        end
        // Bisync pairs the two sync words
        if (ld_kind == `STX_K_SYNC) begin
          sync2_pend_q <= bisync & ~sync2_pend_q;
        end
      end else if (fall && cnt_q != 4'd0) begin
        txd_q <= sr_eff[0];
        sr_q <= {1'b1, sr_eff[7:1]};
        cnt_q <= cnt_q - 4'd1;
        if (abort_now) begin
          crc_abort_q <= 1'b1;
        end
        if (cmd_rst_crc) begin
          crc_q <= `STX_CRC_RST;
        end else if (incl_q) begin
          crc_q <= crc_step(crc_q, sr_eff[0], poly);
        end
      end else if (cmd_rst_crc) begin
        crc_q <= `STX_CRC_RST;
      end
    end
  end

endmodule // stx_sync_tx

// ===== sim/stx_sync_tx_checker.sv
`timescale 1ns/1ps
`include "stx_defs.vh"
// Port-level watch on the transmitter
module stx_sync_tx_checker (
  input wire pclk, // Clock
  input wire presetn, // Reset
  input wire psel, // Select
  input wire penable, // Access
  input wire pwrite, // Write
  input wire [7:0] paddr, // Address
  input wire [31:0] pwdata, // Wdata
  input wire [31:0] prdata, // Rdata
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire serial_tx_clock, // Link clk
  input wire tx_auto_enable, // Auto en
  input wire serial_tx_data, // Line
  input wire tx_service_request, // DMA req
  input wire tx_int_req, // Tx int
  input wire ext_int_req // Ext int
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed accesses; prdata is loaded a cycle early, hence $past below
  wire acc = psel && penable;
  wire wr_dat = acc && pwrite && paddr == `STX_DATA_OFS;
  wire wr_cmd = acc && pwrite && paddr == `STX_CMD_OFS;
  wire rd_st = acc && !pwrite && paddr == `STX_STAT_OFS;
  property p_dat; wr_dat |=> !tx_service_request; endproperty
  a_dat: assert property (p_dat) else $error("request after data write");
  property p_txc; wr_cmd && pwdata[2] |=> !tx_int_req && !tx_service_request; endproperty
  a_txc: assert property (p_txc) else $error("tx int not cleared");
  property p_ext; wr_cmd && pwdata[3] |=> !ext_int_req; endproperty
  a_ext: assert property (p_ext) else $error("ext int not cleared");
  property p_rst; $rose(presetn) |-> serial_tx_data; endproperty
  a_rst: assert property (p_rst) else $error("line not marking");
  property p_edge; $changed(serial_tx_data) |-> !$past(serial_tx_clock, 2); endproperty
  a_edge: assert property (p_edge) else $error("bit off falling edge");
  property p_req; rd_st && $past(tx_service_request) |-> prdata[0]; endproperty
  a_req: assert property (p_req) else $error("request without empty");
  property p_stx; rd_st |-> prdata[2] == $past(tx_int_req); endproperty
  a_stx: assert property (p_stx) else $error("tx int status");
  property p_sext; rd_st |-> prdata[3] == $past(ext_int_req); endproperty
  a_sext: assert property (p_sext) else $error("ext int status");
endmodule // stx_sync_tx_checker

bind stx_sync_tx stx_sync_tx_checker stx_sync_tx_checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_tx_clock(serial_tx_clock),
  .tx_auto_enable(tx_auto_enable), .serial_tx_data(serial_tx_data),
  .tx_service_request(tx_service_request), .tx_int_req(tx_int_req), .ext_int_req(ext_int_req));

// ===== sim/stx_rx_model.sv
`timescale 1ns/1ps
// Far-end receiver: rebuilds characters from the line, lsb first
module stx_rx_model (
  input wire serial_tx_clock, // Link clk
  input wire serial_tx_data, // Line
  output logic [7:0] win, // Last 8 bits
  output int nbits // Bits seen
);
  initial begin
    win = 8'hFF;
    nbits = 0;
  end
  // Falling edge: the sender's synchroniser lands bits too near the rise
  always @(negedge serial_tx_clock) begin
    win <= {serial_tx_data, win[7:1]};
    nbits <= nbits + 1;
  end
endmodule // stx_rx_model

// ===== sim/stx_sync_tx_tb_top.sv
`timescale 1ns/1ps
`include "stx_defs.vh"
module stx_sync_tx_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic serial_tx_clock = 1, tx_auto_enable = 1, e;
  logic [7:0] paddr = 8'h00, win;
  logic [31:0] pwdata = 32'h0000_0000, r;
  logic [15:0] crc;
  int nbits, n0, mismatches = 0, samples_checked = 0;
  wire [31:0] prdata;
  wire pready, pslverr, serial_tx_data, tx_service_request, tx_int_req, ext_int_req;
  always #50 pclk = ~pclk;
  // Link clock offset so its edges never meet pclk edges
  initial begin
    #137;
    forever #400 serial_tx_clock = ~serial_tx_clock;
  end
  stx_sync_tx stx_sync_tx_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_tx_clock(serial_tx_clock), .tx_auto_enable(tx_auto_enable),
    .serial_tx_data(serial_tx_data), .tx_service_request(tx_service_request),
    .tx_int_req(tx_int_req), .ext_int_req(ext_int_req));
  stx_rx_model stx_rx_model_i (.serial_tx_clock(serial_tx_clock),
    .serial_tx_data(serial_tx_data), .win(win), .nbits(nbits));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // One APB transfer; the watchdog ends a hang on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-raises psel in this time step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic stat(input logic [7:0] exp);
    apb(1'b0, `STX_STAT_OFS, 8'h00);
    chk(r[7:0], exp);
  endtask
  // Marks the fall that launched a freshly loaded character
  task automatic wait_load;
    for (int i = 0; i < 200 && tx_int_req !== 1'b1; i++) @(posedge pclk);
    n0 = nbits;
  endtask
  task automatic byte_at(input int k, input logic [7:0] exp);
    for (int i = 0; i < 400 && nbits < n0 + 8 * (k + 1); i++) @(posedge pclk);
    chk(win, exp);
  endtask
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction
  task automatic t_reset;
    stat(8'h03);
    apb(1'b0, 8'h40, 8'h00);
    chk_bit(e, 1'b1);
    chk(r[7:0], 8'h00);
    $display("test reset done");
  endtask
  task automatic t_crc_end;
    wr(`STX_CTRL_OFS, 8'h03);
    wr(`STX_CMD_OFS, 8'h0F);
    wr(`STX_DATA_OFS, 8'h3C);
    stat(8'h30);
    wait_load;
    chk_bit(tx_service_request, 1'b1);
    wr(`STX_CMD_OFS, 8'h04);
    @(posedge pclk);
    chk_bit(tx_service_request, 1'b0);
    crc = crc8(16'h0000, 8'h3C);
    byte_at(0, 8'h3C);
    byte_at(1, crc[7:0]);
    stat(8'h6A);
    byte_at(2, crc[15:8]);
    byte_at(3, 8'h3C);
    stat(8'h2F);
    wr(`STX_CMD_OFS, 8'h08);
    @(posedge pclk);
    chk_bit(ext_int_req, 1'b0);
    $display("test crc end done");
  endtask
  task automatic t_bisync;
    wr(`STX_CTRL_OFS, 8'h05);
    wr(`STX_CMD_OFS, 8'h0C);
    wr(`STX_DATA_OFS, 8'h5A);
    wait_load;
    byte_at(0, 8'h5A);
    byte_at(1, 8'h3C);
    stat(8'h2F);
    byte_at(2, 8'hA5);
    $display("test bisync done");
  endtask
  task automatic t_disable;
    wr(`STX_CTRL_OFS, 8'h00);
    wr(`STX_CMD_OFS, 8'h0C);
    wr(`STX_DATA_OFS, 8'hC3);
    n0 = nbits;
    byte_at(2, 8'hFF);
    stat(8'h12);
    $display("test disable done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    wr(`STX_SYNC1_OFS, 8'h3C);
    wr(`STX_SYNC2_OFS, 8'hA5);
    t_crc_end;
    t_bisync;
    t_disable;
    conclude;
  end
  // Watchdog: about 13 link characters are needed, far below 1 ms
  initial begin
    #1000000;
    mismatches++;
    conclude;
  end
endmodule // stx_sync_tx_tb_top
